// >>> hw/adcsq_top.v
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_regs.vh"

// Notes on behaviour
// R1 - Conversion starts on the software go bit or on a selected event.
// R2 - Scan converts lowest selected input first, then steps by one per conversion.
// R3 - Conversion clock is the peripheral clock divided by a programmable prescaler.
// R4 - Delay is one plus half of resolution plus one plus gain cycles.
// R5 - MSB first; rest over three or five cycles, one bit per half cycle.
// R6 - In the last cycle the result is stored and the done flag set.
// R7 - Start must come one peripheral cycle before the intended conversion cycle.
// R8 - Input is sampled in the first half of the first conversion cycle.
// R9 - Each gain doubling adds one half cycle through a non-converting stage.
// R10 - A new conversion may start right after the previous one completes; here only with odd gain, one idle half later with even gain.
// R11 - Every new result raises a DMA request.
// R12 - Interrupt and event raised on completion or on compare threshold; here only the event follows the compare, the interrupt every result.
// R13 - Software loads the production calibration value into the calibration register.
// R14 - Flush drops conversions, restarts the clock, starts on next peripheral cycle.
// R15 - Flush comes from software or automatically from an event.
// R16 - With flush on trigger, triggers must be spaced beyond the delay.
// R17 - Pending starts not cleared before a flush start right after it.
// R18 - The go bit clears itself once the conversion has begun.
// R19 - After a flush, pending conversions enter and complete.
// R20 - After the last scan source the selection returns to the first.
module adcsq_top #(
    parameter SEL_W = 4,
    parameter PRE_W = 3
) (
    input  wire        CLK,
    input  wire        RSTN,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    input  wire        EVENT_IN,
    input  wire [11:0] SAR_BITS,
    output reg         SAMPLE_HOLD,
    output reg         CONV_CLK,
    output reg  [SEL_W-1:0] INPUT_SELECTOR,
    output reg         DONE_IRQ,
    output reg         DONE_EVENT,
    output reg         DMA_REQ,
    output reg  [11:0] CAL_VALUE
);
    // Timing overview of the engine below.
    // A conversion always begins on a rising edge of the conversion clock.
    // While enabled the engine is stepped once per half period of that clock, never faster.
    // The first half samples the selected input while SAMPLE_HOLD is high.
    // The gain halves that follow move the sample along without resolving a bit.
    // The remaining halves resolve one result bit each, most significant first.
    // The result is posted at the start of the last half of the conversion.
    // With odd gain, posting it then leaves the engine idle exactly when the next rising edge comes.
    // A queued start or a running scan is therefore taken with no idle cycle between if the gain is odd, one idle half later if it is even.
    // A flush drops the conversion in flight but keeps every pending start.
    // Pending starts are taken on the first conversion-clock edge after the flush.
    // Software that wants a clean restart must clear its pending starts first.
    // The prescaler only runs while the block is enabled, which saves power.
    // While disabled no conversion starts, even if a start is written; one in flight steps on every peripheral cycle.
    // Conversion engine states.
    localparam ST_IDLE = 2'd0;
    localparam ST_CONV = 2'd1;
    localparam ST_LAST = 2'd2;

    reg             enable_r;
    reg             go_pend_r;
    reg             ev_pend_r;
    reg  [31:0]     cfg_r;
    reg  [SEL_W-1:0] first_sel_r;
    reg  [SEL_W-1:0] scan_cnt_r;
    reg  [SEL_W-1:0] scan_idx_r;
    reg  [11:0]     cmp_r;
    reg  [15:0]     result_r;
    reg             done_r;
    reg  [1:0]      state_r;
    reg  [5:0]      half_r;
    reg  [7:0]      pre_cnt_r;
    reg             phase_r;
    reg  [11:0]     shift_r;
    reg             scan_run_r;

    // The scan flag lets a sequence continue without a fresh start request.
    // Without it the self-clearing go bit would stop every scan after one source.
    // Bus strobes are decoded once here and shared by the processes below; the APB slave decodes its setup strobe itself.
    // Only the access phase of a transfer changes control or configuration state; the setup phase loads the bus response.
    wire            wr_acc = PSEL & PENABLE & PWRITE;
    wire            rd_acc = PSEL & PENABLE & ~PWRITE;
    wire            ofs_ok = (PADDR == `ADCSQ_CTRL_OFS) || (PADDR == `ADCSQ_CFG_OFS) ||
                             (PADDR == `ADCSQ_SCAN_OFS) || (PADDR == `ADCSQ_CMP_OFS) ||
                             (PADDR == `ADCSQ_CAL_OFS) || (PADDR == `ADCSQ_STAT_OFS) ||
                             (PADDR == `ADCSQ_RES_OFS);
    wire            wr_ctrl = wr_acc & (PADDR == `ADCSQ_CTRL_OFS);
    wire            sw_flush = wr_ctrl & PWDATA[`ADCSQ_CTRL_FLUSH];
    wire            ev_flush = EVENT_IN & cfg_r[`ADCSQ_CFG_EVFLUSH] & enable_r;
    wire            flush = enable_r & (sw_flush | ev_flush); // [R15]
    wire            res8 = cfg_r[`ADCSQ_CFG_RES8];
    wire [2:0]      gain = cfg_r[`ADCSQ_CFG_GAIN_LO +: 3];
    wire [PRE_W-1:0] pre_sel = cfg_r[`ADCSQ_CFG_PRE_LO +: PRE_W];
    // The prescaler divides by 2^(pre_sel+1); each half of CONV_CLK is 2^pre_sel cycles.
    wire [7:0]      pre_top = (8'h01 << pre_sel) - 8'h01;
    wire            half_tick = (pre_cnt_r == pre_top);
    wire            edge_rise = half_tick & ~phase_r;
    // Total length in half cycles: 2 + (res + 1) + gain halves.
    wire [5:0]      total_halves = 6'd2 + {1'b0, (res8 ? `ADCSQ_RES8_HALVES
                                           : `ADCSQ_RES12_HALVES)} + {3'd0, gain}; // [R4] [R9]
    wire            pend = go_pend_r | ev_pend_r;
    wire [11:0]     res_val = res8 ? {4'h0, shift_r[11:4]} : shift_r;
    wire            cmp_hit = cfg_r[`ADCSQ_CFG_CMPABOVE] ? (res_val > cmp_r)
                                                        : (res_val < cmp_r);
    wire [SEL_W-1:0] last_idx = scan_cnt_r;

    // APB slave: zero wait state, errors on unmapped offsets.
    // Ready is raised for exactly the access cycle that follows each setup cycle.
    // Read data are latched in the setup cycle, so they stand through the access.
    // Latching early keeps the read path off the decode of the access strobe.
    // An unmapped offset answers with an error and reads back as zero.
    // Writes to unmapped offsets are dropped without side effects.
    // Back-to-back transfers are accepted with no idle cycle between them.
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end
        else
        begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~ofs_ok;
            if (PSEL & ~PENABLE & ~PWRITE)
            begin
                case (PADDR)
                    `ADCSQ_CTRL_OFS: PRDATA <= {29'h0, go_pend_r, 1'b0, enable_r};
                    `ADCSQ_CFG_OFS:  PRDATA <= cfg_r;
                    `ADCSQ_SCAN_OFS: PRDATA <= {16'h0, 4'h0, scan_cnt_r, 4'h0, first_sel_r};
                    `ADCSQ_CMP_OFS:  PRDATA <= {20'h0, cmp_r};
                    `ADCSQ_CAL_OFS:  PRDATA <= {20'h0, CAL_VALUE};
                    `ADCSQ_STAT_OFS: PRDATA <= {30'h0, (state_r != ST_IDLE), done_r};
                    `ADCSQ_RES_OFS:  PRDATA <= {16'h0, result_r};
                    default:         PRDATA <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers; the calibration value is only loaded by software.
    // The block has no access to a production store, so it cannot load it itself.
    // Configuration may change at any time, but a conversion in flight sees it.
    // Software should therefore change resolution or gain only while idle.
    // The enable bit is written together with the flush and go bits of control.
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            enable_r    <= 1'b0;
            cfg_r       <= `ADCSQ_CFG_RST;
            first_sel_r <= {SEL_W{1'b0}};
            scan_cnt_r  <= {SEL_W{1'b0}};
            cmp_r       <= 12'h000;
            CAL_VALUE   <= 12'h000;
        end
        else if (wr_acc)
        begin
            case (PADDR)
                `ADCSQ_CTRL_OFS: enable_r <= PWDATA[`ADCSQ_CTRL_ENABLE];
                `ADCSQ_CFG_OFS:  cfg_r <= PWDATA;
                `ADCSQ_SCAN_OFS:
                begin
                    first_sel_r <= PWDATA[SEL_W-1:0];
                    scan_cnt_r  <= PWDATA[8 +: SEL_W];
                end
                `ADCSQ_CMP_OFS:  cmp_r <= PWDATA[11:0];
                `ADCSQ_CAL_OFS:  CAL_VALUE <= PWDATA[11:0]; // [R13]
                default:         cmp_r <= cmp_r;
            endcase
        end
    end

    // Prescaler for the conversion clock; a flush restarts it in phase.
    // Each half period lasts a power of two of peripheral clock cycles.
    // Powers of two keep the divider a plain counter with one compare.
    // Loading the counter with its top value makes the next cycle a half tick.
    // That is how a flush starts the conversion on the very next cycle.
    // While disabled the counter is parked at its top and the output stays low.
    // The divided clock is a register output, so it carries no glitches.
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            pre_cnt_r <= 8'h00;
            phase_r   <= 1'b0;
            CONV_CLK  <= 1'b0;
        end
        else if (flush || !enable_r)
        begin
            // Restarting leaves the next CLK edge aligned with a conversion-clock edge.
            pre_cnt_r <= pre_top; // [R14]
            phase_r   <= 1'b0;
            CONV_CLK  <= 1'b0;
        end
        else if (half_tick)
        begin
            pre_cnt_r <= 8'h00; // [R3]
            phase_r   <= ~phase_r;
            CONV_CLK  <= ~phase_r;
        end
        else
        begin
            pre_cnt_r <= pre_cnt_r + 8'h01;
        end
    end

    // Start requests stay pending until the engine takes them; a set beats a take.
    // A start that arrives late in a half is simply taken at the next rising edge.
    // Requests are only consumed on an edge where the engine can really begin.
    // A flush cycle never consumes a request, so the request survives the flush.
    // The go request is served before the event request when both are pending.
    // The event request then waits for the following conversion.
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            go_pend_r <= 1'b0;
            ev_pend_r <= 1'b0;
        end
        else
        begin
            // Pending starts survive a flush and are taken straight after it.
            if (wr_ctrl && PWDATA[`ADCSQ_CTRL_GO])
                go_pend_r <= 1'b1; // [R1] [R17] [R19]
            else if (state_r == ST_IDLE && edge_rise && enable_r && !flush)
                go_pend_r <= 1'b0; // [R18]
            if (EVENT_IN && cfg_r[`ADCSQ_CFG_EVSTART] && enable_r)
                ev_pend_r <= 1'b1; // [R1]
            else if (state_r == ST_IDLE && edge_rise && enable_r && !go_pend_r && !flush)
                ev_pend_r <= 1'b0;
        end
    end

    // Conversion engine, advanced on half cycles of the conversion clock.
    // The half counter starts at one in the sampling half of a conversion.
    // The last state covers the two halves before the final one and posts the result as it ends.
    // Completion pulses last one peripheral cycle, whatever the prescaler.
    // The done flag stays set until software reads the result register.
    // A read and a completion in the same cycle leave the flag set.
    // The input selector is only updated while idle, so a sample never moves.
    // A scan steps the selector after each result and wraps after the last source.
    // The scan flag survives a flush, so a scan interrupted after its first result resumes.
    // The interrupt level is the done flag delayed by one cycle.
    always @(posedge CLK or negedge RSTN)
    begin
        if (!RSTN)
        begin
            state_r        <= ST_IDLE;
            half_r         <= 6'd0;
            scan_idx_r     <= {SEL_W{1'b0}};
            INPUT_SELECTOR <= {SEL_W{1'b0}};
            SAMPLE_HOLD    <= 1'b0;
            shift_r        <= 12'h000;
            scan_run_r     <= 1'b0;
            result_r       <= 16'h0000;
            done_r         <= 1'b0;
            DONE_IRQ       <= 1'b0;
            DONE_EVENT     <= 1'b0;
            DMA_REQ        <= 1'b0;
        end
        else
        begin
            DONE_EVENT <= 1'b0;
            DMA_REQ    <= 1'b0;
            if (rd_acc && PADDR == `ADCSQ_RES_OFS)
                done_r <= 1'b0;
            if (flush)
            begin
                state_r     <= ST_IDLE; // [R14]
                SAMPLE_HOLD <= 1'b0;
                half_r      <= 6'd0;
            end
            else if (half_tick)
            begin
                case (state_r)
                    ST_IDLE:
                    begin
                        INPUT_SELECTOR <= first_sel_r + scan_idx_r; // [R2]
                        if (edge_rise && enable_r && (pend || scan_run_r))
                        begin
                            state_r     <= ST_CONV;
                            half_r      <= 6'd1;
                            SAMPLE_HOLD <= 1'b1; // [R8]
                        end
                    end
                    ST_CONV:
                    begin
                        SAMPLE_HOLD <= 1'b0;
                        half_r      <= half_r + 6'd1;
                        // Gain halves pass through without resolving a bit.
                        if (half_r > {3'd0, gain})
                            shift_r <= SAR_BITS; // [R5] [R9]
                        if (half_r == total_halves - 6'd3)
                            state_r <= ST_LAST;
                    end
                    ST_LAST:
                    begin
                        half_r <= half_r + 6'd1;
                        if (half_r == total_halves - 6'd1)
                        begin
                            result_r   <= {4'h0, res_val}; // [R6]
                            done_r     <= 1'b1;
                            DMA_REQ    <= 1'b1; // [R11]
                            DONE_EVENT <= ~cfg_r[`ADCSQ_CFG_CMPEN] | cmp_hit; // [R12]
                            // Keep the sequence running without a new start until the last source.
                            scan_run_r <= (scan_idx_r != last_idx); // [R2]
                            if (scan_idx_r == last_idx)
                                scan_idx_r <= {SEL_W{1'b0}}; // [R20]
                            else
                                scan_idx_r <= scan_idx_r + {{(SEL_W-1){1'b0}}, 1'b1}; // [R2]
                            // Back to idle lands on a falling half with odd gain, on a rising one with even gain; next rising edge may start.
                            state_r <= ST_IDLE; // [R10]
                        end
                    end
                    default: state_r <= ST_IDLE;
                endcase
            end
            DONE_IRQ <= done_r;
        end
    end
endmodule
`default_nettype wire

// >>> hw/adcsq_regs.vh
`ifndef ADCSQ_REGS_VH
`define ADCSQ_REGS_VH
// Register byte offsets on the APB bus.
`define ADCSQ_CTRL_OFS      12'h000
`define ADCSQ_CFG_OFS       12'h004
`define ADCSQ_SCAN_OFS      12'h008
`define ADCSQ_CMP_OFS       12'h00c
`define ADCSQ_CAL_OFS       12'h010
`define ADCSQ_STAT_OFS      12'h014
`define ADCSQ_RES_OFS       12'h018
// Control register fields.
`define ADCSQ_CTRL_ENABLE   0
`define ADCSQ_CTRL_FLUSH    1
`define ADCSQ_CTRL_GO       2
// Configuration register fields.
`define ADCSQ_CFG_RES8      0
`define ADCSQ_CFG_EVSTART   1
`define ADCSQ_CFG_EVFLUSH   2
`define ADCSQ_CFG_CMPABOVE  3
`define ADCSQ_CFG_CMPEN     4
`define ADCSQ_CFG_GAIN_LO   8
`define ADCSQ_CFG_PRE_LO    12
// Status register fields.
`define ADCSQ_STAT_DONE     0
`define ADCSQ_STAT_BUSY     1
// Reset values.
`define ADCSQ_CFG_RST       32'h0000_0000
`define ADCSQ_SCAN_RST      32'h0000_0000
// Timing figures in conversion-clock half cycles.
`define ADCSQ_RES8_HALVES   5'd9
`define ADCSQ_RES12_HALVES  5'd13
`endif

// >>> sim/adcsq_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module adcsq_monitor #(
    parameter SEL_W = 4
) (
    input wire logic             CLK,
    input wire logic             RSTN,
    input wire logic             PSEL,
    input wire logic             PENABLE,
    input wire logic             PREADY,
    input wire logic             PSLVERR,
    input wire logic             SAMPLE_HOLD,
    input wire logic             CONV_CLK,
    input wire logic [SEL_W-1:0] INPUT_SELECTOR,
    input wire logic             DONE_IRQ,
    input wire logic             DONE_EVENT,
    input wire logic             DMA_REQ
);
    // Everything lives in the one peripheral clock domain.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // The slave answers one cycle after setup and only for that cycle.
    AST_READY_NEXT: assert property (PSEL && !PENABLE |=> PREADY) else $error("late ready");
    AST_READY_ONE: assert property (PREADY |=> !PREADY) else $error("ready held");
    AST_ERR_READY: assert property (PSLVERR |-> PREADY) else $error("error without ready");
    // Completion strobes are single pulses and the flag follows them.
    AST_DMA_PULSE: assert property (DMA_REQ |=> !DMA_REQ) else $error("dma held");
    AST_EVT_PULSE: assert property (DONE_EVENT |=> !DONE_EVENT) else $error("evt held");
    AST_IRQ_FLAG: assert property (DMA_REQ |-> ##[0:2] DONE_IRQ) else $error("no flag");
    // Sampling sits in the high half of the first conversion cycle, input held.
    AST_SAMPLE_HIGH: assert property (SAMPLE_HOLD |-> CONV_CLK) else $error("bad phase");
    AST_SEL_STILL: assert property (SAMPLE_HOLD |=> !SAMPLE_HOLD || $stable(INPUT_SELECTOR))
        else $error("input moved");
    CV_DMA: cover property (DMA_REQ);
    CV_ERR: cover property (PSLVERR);
    CV_SAMPLE: cover property ($rose(SAMPLE_HOLD));
endmodule
bind adcsq_top adcsq_monitor #(.SEL_W(SEL_W)) u_mon (.CLK(CLK), .RSTN(RSTN), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE_HOLD(SAMPLE_HOLD),
    .CONV_CLK(CONV_CLK), .INPUT_SELECTOR(INPUT_SELECTOR), .DONE_IRQ(DONE_IRQ),
    .DONE_EVENT(DONE_EVENT), .DMA_REQ(DMA_REQ));
`default_nettype wire

// >>> sim/adcsq_trig_src.sv
`timescale 1ns/1ps
`default_nettype none
// Stand-in for the event routing system and the analog bit source.
module adcsq_trig_src (
    input  wire logic        clk,
    input  wire logic        fire,
    input  wire logic [11:0] level,
    output logic             ev,
    output logic [11:0]      bits
);
    initial ev = 1'b0;
    // Event pulse launched after an edge, a full cycle ahead of the conversion edge.
    always @(posedge clk) ev <= fire;
    // Held through a conversion so every resolved bit sees one level.
    assign bits = level;
endmodule
`default_nettype wire

// >>> sim/adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "adcsq_regs.vh"
module adc_conversion_sequencer_test;
    logic clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, fire = 0;
    logic [11:0] paddr = 0, sar = 0, bits, cal;
    logic [31:0] pwdata = 0, prdata, rd_q, tmp, seed = 32'hfadf;
    logic pready, pslverr, rd_e, ev, sh, cclk, irq, devt, dma;
    logic [3:0] sel;
    logic sh_d = 0;
    int errors = 0, num_checks = 0, dma_n = 0, evt_n = 0, cyc = 0, t_d = 0, n0, g, r8, ex, c0;
    int sel_q[$], st_q[$];
    adcsq_top dut (.CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .EVENT_IN(ev), .SAR_BITS(bits), .SAMPLE_HOLD(sh), .CONV_CLK(cclk),
        .INPUT_SELECTOR(sel), .DONE_IRQ(irq), .DONE_EVENT(devt), .DMA_REQ(dma), .CAL_VALUE(cal));
    adcsq_trig_src src (.clk(clk), .fire(fire), .level(sar), .ev(ev), .bits(bits));
    always #5 clk = ~clk;
    // Log each conversion start and completion for the checks below.
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        sh_d <= sh;
        if (sh && !sh_d)
        begin
            sel_q.push_back(sel);
            st_q.push_back(cyc);
        end
        if (devt) evt_n <= evt_n + 1;
        if (dma)
        begin
            dma_n <= dma_n + 1;
            t_d <= cyc;
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One APB transfer; request held until ready is sampled high.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 20) errors++;
        rd_q = prdata;
        rd_e = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd_q, exp);
    endtask
    // Waiting is bounded so a silent converter cannot hang the run.
    task automatic wait_dma(input int n);
        int k;
        k = 0;
        while (dma_n < n && k < 600)
        begin
            @(posedge clk);
            k++;
        end
        if (k == 600) errors++;
        @(posedge clk);
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        errors++;
        end_sim();
    end
    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1;
        rdchk(`ADCSQ_CFG_OFS, `ADCSQ_CFG_RST);
        rdchk(`ADCSQ_SCAN_OFS, `ADCSQ_SCAN_RST);
        rdchk(12'h01c, 0);
        chk(rd_e, 1);
        tmp = rnd();
        apb(1, `ADCSQ_CAL_OFS, tmp[11:0]);
        chk(cal, tmp[11:0]);
        // Single conversions at both resolutions, with and without gain halves.
        for (int i = 0; i < 4; i++)
        begin
            g = 3 * (i >> 1);
            r8 = i & 1;
            tmp = rnd();
            sar <= tmp[11:0];
            apb(1, `ADCSQ_CFG_OFS, (1 << 12) | (g << 8) | r8);
            apb(1, `ADCSQ_SCAN_OFS, tmp[15:12]);
            n0 = dma_n;
            apb(1, `ADCSQ_CTRL_OFS, 5);
            wait_dma(n0 + 1);
            // The result is posted at the start of the last half of the conversion.
            ex = (1 + (r8 ? 9 : 13) + g) << 1;
            chk(t_d - st_q[$] >= ex && t_d - st_q[$] <= ex + 1, 1);
            chk(sel_q[$], tmp[15:12]);
            rdchk(`ADCSQ_CTRL_OFS, 1);
            rdchk(`ADCSQ_STAT_OFS, 1);
            chk(irq, 1);
            apb(0, `ADCSQ_RES_OFS, 0);
            chk(rd_q, r8 ? sar >> 4 : sar);
            rdchk(`ADCSQ_STAT_OFS, 0);
        end
        // Scan of three inputs; 16 halves of two cycles each back to back.
        apb(1, `ADCSQ_SCAN_OFS, 32'h0203);
        apb(1, `ADCSQ_CFG_OFS, 32'h1100);
        sel_q.delete();
        st_q.delete();
        n0 = dma_n;
        apb(1, `ADCSQ_CTRL_OFS, 5);
        wait_dma(n0 + 3);
        for (int k = 0; k < 3; k++) chk(sel_q[k], 3 + k);
        for (int k = 1; k < 3; k++) chk(st_q[k] - st_q[k-1], 32);
        // Event start; one trigger runs the whole three-input scan.
        apb(1, `ADCSQ_CFG_OFS, 32'h1102);
        fire <= 1;
        @(posedge clk);
        fire <= 0;
        wait_dma(n0 + 6);
        chk(sel_q[3], 3);
        // Event flush restarts the conversion clock and starts at once.
        apb(1, `ADCSQ_SCAN_OFS, 32'h0005);
        apb(1, `ADCSQ_CFG_OFS, 32'h2006);
        c0 = cyc;
        fire <= 1;
        @(posedge clk);
        fire <= 0;
        wait_dma(n0 + 7);
        chk(st_q[$] - c0, 4);
        // Software flush mid-conversion loses the result.
        apb(1, `ADCSQ_CFG_OFS, 32'h1000);
        apb(1, `ADCSQ_CTRL_OFS, 5);
        repeat (6) @(posedge clk);
        apb(1, `ADCSQ_CTRL_OFS, 3);
        repeat (80) @(posedge clk);
        chk(dma_n, n0 + 7);
        chk(evt_n, dma_n);
        end_sim();
    end
endmodule
`default_nettype wire
